// ### wdt_core_model.sv
// Purpose: Core-side interval interrupt flag seen by the timer.
// Assumes: Software writes of the flag arrive as a level pair.
// Notes:   A software write wins over an overflow in the same cycle.
`timescale 1ns/1ps
module wdt_core_model (
   input  wire logic clk_sys,
   input  wire logic rst,
   input  wire logic set_pulse,
   input  wire logic sw_wr,
   input  wire logic sw_val,
   output logic      flag_ff
);
   // ==========================================================
   // Flag register
   // The flag holds until software rewrites it, as in the core.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         flag_ff <= 1'b0;
      end else if (sw_wr) begin
         flag_ff <= sw_val;
      end else if (set_pulse) begin
         flag_ff <= 1'b1;
      end
   end
endmodule

// ### wdt_pkg.sv
// Purpose: Shared constants and types for the watchdog/interval timer.
// Assumes: Byte-wide special register writes from the processor core.
// Notes:   Offsets are the core's special register addresses.
package wdt_pkg;

   // ==========================================================
   // Register map
   localparam logic [15:0] WDT_CLKSEL_ADDR = 16'hFF42;
   localparam logic [15:0] WDT_MODE_ADDR   = 16'hFFF9;
   localparam logic [7:0]  WDT_RESET_VAL   = 8'h00;

   // ==========================================================
   // Field positions
   localparam int WDT_RUN_POS   = 7;
   localparam int WDT_MUP_POS   = 4;
   localparam int WDT_MLO_POS   = 3;
   localparam logic [7:0] WDT_CLKSEL_MASK = 8'h07;
   localparam logic [7:0] WDT_MODE_MASK   = 8'h98;

   // ==========================================================
   // Timing: prescaler taps and counter length
   localparam int WDT_PRESC_W  = 10;
   localparam int WDT_CNT_W    = 7;
   localparam int WDT_TAP_BASE = 4;
   localparam logic [6:0] WDT_CNT_LAST = 7'h7F;

   // Operating modes held in the two mode bits.
   typedef enum logic [1:0] {
      WDT_MODE_STOP     = 2'b00,
      WDT_MODE_INTERVAL = 2'b01,
      WDT_MODE_NMI      = 2'b10,
      WDT_MODE_RESET    = 2'b11
   } wdt_mode_t;

   // Register write request from the core.
   typedef struct packed {
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  data;
   } wdt_wr_t;

endpackage

// ### wdt_timer.sv
// Purpose: Watchdog / interval timer on a free-running prescaler.
// Assumes: Writes and stop/halt levels are synchronous to clk_sys.
// Notes:   Overflow events are one-cycle registered pulses.
//
// Behaviour
// - Clock select picks four overflow periods.
// - Reset clears both registers to zero.
// - Writing run bit clears and starts counter.
// - Run bit cannot be cleared by software.
// - Mode field selects stop/interval/NMI/reset.
// - Each mode bit sticky once set.
// - Watchdog overflow gives reset or NMI.
// - First period after restart may be shorter.
// - Interval mode interrupts at every period.
// - Mask flag gates the interval interrupt.
// - Interval interrupt has top maskable priority.
// - Watchdog entry with flag set gives NMI.
// - Counting continues in halt, freezes in stop.
`timescale 1ns/1ps

module wdt_timer
   import wdt_pkg::*;
(
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire wdt_pkg::wdt_wr_t wr_req,
   input  wire logic             stop_mode,
   input  wire logic             irq_flag_in,
   input  wire logic             irq_mask_in,
   output logic [7:0]            clksel_rd,
   output logic [7:0]            mode_rd,
   output logic                  irq_flag_set,
   output logic                  irq_req,
   output logic                  irq_top_prio,
   output logic                  nmi_req,
   output logic                  sys_reset_req
);
   import wdt_pkg::*;

   logic [2:0]             clksel_ff;
   logic                   run_ff;
   logic [1:0]             mode_ff;
   logic [WDT_PRESC_W-1:0] presc_ff;
   logic [WDT_PRESC_W-1:0] presc_prev_ff;
   logic [WDT_CNT_W-1:0]   cnt_ff;
   logic [7:0]             clksel_rd_ff;
   logic [7:0]             mode_rd_ff;
   logic                   irq_set_ff;
   logic                   irq_req_ff;
   logic                   irq_prio_ff;
   logic                   nmi_ff;
   logic                   rst_req_ff;
   logic                   tick;
   logic                   ovf;
   logic                   wr_clk;
   logic                   wr_mode;
   logic [1:0]             nxt_mode;
   int                     tap;

   // ==========================================================
   // Register decode
   assign wr_clk  = wr_req.wr && (wr_req.addr == WDT_CLKSEL_ADDR);
   assign wr_mode = wr_req.wr && (wr_req.addr == WDT_MODE_ADDR);
   // Mode bits only ever accumulate ones; zeros are ignored.
   assign nxt_mode = mode_ff |
      {wr_req.data[WDT_MUP_POS], wr_req.data[WDT_MLO_POS]};

   // Clock select is a plain 3-bit register; reset gives the shortest period.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clksel_ff <= WDT_RESET_VAL[2:0];
      end else if (wr_clk) begin
         clksel_ff <= wr_req.data[2:0];
      end
   end

   // Mode register: run and mode bits are sticky until reset.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         run_ff  <= 1'b0;
         mode_ff <= 2'b00;
      end else if (wr_mode) begin
         run_ff  <= run_ff | wr_req.data[WDT_RUN_POS];
         mode_ff <= nxt_mode;
      end
   end

   // ==========================================================
   // Free-running prescaler; it freezes in stop so the count holds too.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         presc_ff      <= '0;
         presc_prev_ff <= '0;
      end else if (!stop_mode) begin
         presc_ff      <= presc_ff + 1'b1;
         presc_prev_ff <= presc_ff;
      end
   end

   // Selected tap rises once per prescaled period. Codes with bit0 set
   // are prohibited; they fall back onto the even code below them.
   assign tap  = WDT_TAP_BASE - 1 + 2 * int'(clksel_ff[2:1]);
   assign tick = !stop_mode && presc_ff[tap] && !presc_prev_ff[tap];
   assign ovf  = tick && (cnt_ff == WDT_CNT_LAST);

   // Timeout counter. A restart does not touch the prescaler, so the
   // first period is short by part of one tick (under 1/128).
   // A restart that lands on a tick edge wins, so that tick is dropped.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cnt_ff <= '0;
      end else if (wr_mode && wr_req.data[WDT_RUN_POS]) begin
         cnt_ff <= '0;
      end else if (run_ff && tick) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // ==========================================================
   // Overflow actions, registered so outputs come from flip-flops.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         irq_set_ff  <= 1'b0;
         irq_req_ff  <= 1'b0;
         irq_prio_ff <= 1'b0;
         nmi_ff      <= 1'b0;
         rst_req_ff  <= 1'b0;
      end else begin
         irq_set_ff <= run_ff && ovf &&
                       (mode_ff == WDT_MODE_INTERVAL);
         irq_req_ff <= irq_flag_in && !irq_mask_in &&
                       (mode_ff == WDT_MODE_INTERVAL);
         // Always top among maskable sources when requesting.
         irq_prio_ff <= irq_flag_in && !irq_mask_in &&
                        (mode_ff == WDT_MODE_INTERVAL);
         nmi_ff <= (run_ff && ovf && mode_ff == WDT_MODE_NMI) ||
                   (wr_mode && nxt_mode[1] && !mode_ff[1] &&
                    irq_flag_in);
         rst_req_ff <= run_ff && ovf &&
                       (mode_ff == WDT_MODE_RESET);
      end
   end

   // Readback images; reserved bits read as zero.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         clksel_rd_ff <= WDT_RESET_VAL;
         mode_rd_ff   <= WDT_RESET_VAL;
      end else begin
         clksel_rd_ff <= {5'h00, clksel_ff};
         mode_rd_ff   <= {run_ff, 2'b00, mode_ff, 3'b000};
      end
   end

   assign clksel_rd     = clksel_rd_ff;
   assign mode_rd       = mode_rd_ff;
   assign irq_flag_set  = irq_set_ff;
   assign irq_req       = irq_req_ff;
   assign irq_top_prio  = irq_prio_ff;
   assign nmi_req       = nmi_ff;
   assign sys_reset_req = rst_req_ff;

   // ==========================================================
   // Checks
   // Sticky bits: only reset may take them back to zero.
   run_sticky_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      run_ff |=> run_ff)
      else $error("run bit cleared");
   mode_sticky_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      mode_ff[1] |=> mode_ff[1])
      else $error("upper mode bit cleared");
   low_sticky_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      mode_ff[0] |=> mode_ff[0])
      else $error("lower mode bit cleared");
   // The reset check has no disable clause: it has to see reset itself.
   reset_clear_a: assert property (
      @(posedge clk_sys)
      rst |=> clksel_ff == 3'h0 && mode_ff == 2'b00 && !run_ff)
      else $error("registers not cleared by reset");
   restart_clear_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      wr_mode && wr_req.data[WDT_RUN_POS] |=> cnt_ff == 7'h00)
      else $error("restart did not clear");
   // Without the run bit nothing may count, whatever the mode says.
   idle_count_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      !run_ff |=> cnt_ff == 7'h00)
      else $error("count moved while not running");
   stop_freeze_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      stop_mode && !wr_mode |=> $stable(cnt_ff))
      else $error("count moved in stop");
   // A tick follows a carry into the tap, so the low bits are zero then.
   tick_align_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      tick |-> presc_ff[2:0] == 3'h0)
      else $error("tick off a prescaler boundary");
   // ==========================================================
   // Overflow and interrupt checks
   stop_quiet_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      mode_ff == WDT_MODE_STOP |=> !irq_flag_set && !sys_reset_req)
      else $error("event in stopped mode");
   wd_reset_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      run_ff && ovf && mode_ff == WDT_MODE_RESET |=> sys_reset_req)
      else $error("no reset on overflow");
   wd_nmi_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      run_ff && ovf && mode_ff == WDT_MODE_NMI |=> nmi_req)
      else $error("no nmi on overflow");
   interval_set_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      run_ff && ovf && mode_ff == WDT_MODE_INTERVAL |=> irq_flag_set)
      else $error("no interrupt on overflow");
   interval_irq_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      irq_flag_set |-> $past(mode_ff) == WDT_MODE_INTERVAL)
      else $error("interrupt outside interval mode");
   mask_gate_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      irq_req |-> !$past(irq_mask_in))
      else $error("masked request passed");
   flag_gate_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      irq_req |-> $past(irq_flag_in))
      else $error("request without flag");
   // Entering a watchdog mode with the flag already up must not be missed.
   nmi_entry_a: assert property (
      @(posedge clk_sys) disable iff (rst)
      wr_mode && wr_req.data[WDT_MUP_POS] && !mode_ff[1] && irq_flag_in
      |=> nmi_req)
      else $error("no nmi on entry");
endmodule

// ### wdt_timer_bench.sv
// Purpose: Self-checking bench for the watchdog/interval timer.
// Assumes: Outputs are settled 1 ns after the clock edge.
// Notes:   Clock codes stay below 100 to keep the run short.
`timescale 1ns/1ps
module wdt_timer_bench;
   import wdt_pkg::*;
   logic       clk_sys, rst, stop_mode, irq_mask_in, sw_wr, sw_val;
   wdt_wr_t    wr_req;
   logic [7:0] clksel_rd, mode_rd, d;
   logic       irq_flag_in, irq_flag_set, irq_req, irq_top_prio;
   logic       nmi_req, sys_reset_req;
   logic [2:0] seen;
   int         failures, n_checks, n, p;
   int         seed = 32'hF5330CB9;
   wire logic [2:0] ev = {sys_reset_req, nmi_req, irq_flag_set};
   wdt_timer wdt_timer_inst (.clk_sys(clk_sys), .rst(rst), .wr_req(wr_req),
      .stop_mode(stop_mode), .irq_flag_in(irq_flag_in),
      .irq_mask_in(irq_mask_in), .clksel_rd(clksel_rd), .mode_rd(mode_rd),
      .irq_flag_set(irq_flag_set), .irq_req(irq_req),
      .irq_top_prio(irq_top_prio), .nmi_req(nmi_req),
      .sys_reset_req(sys_reset_req));
   wdt_core_model wdt_core_model_inst (.clk_sys(clk_sys), .rst(rst),
      .set_pulse(irq_flag_set), .sw_wr(sw_wr), .sw_val(sw_val),
      .flag_ff(irq_flag_in));
   // ==========================================================
   // Helpers
   // Pulses are caught here because a write task can span them.
   always @(posedge clk_sys) seen <= seen | ev;
   function automatic int period(input logic [7:0] sel);
      return 1 << (11 + 2 * sel[2:1]);
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk_sys);
      wr_req <= '{1'b1, a, v};
      @(posedge clk_sys);
      wr_req.wr <= 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
   endtask
   // Bounded wait; a missing event leaves n at the limit.
   task automatic wait_ev(input int k, input int lim);
      n = 0;
      do begin
         @(posedge clk_sys);
         #1;
         n++;
      end while (ev[k] !== 1'b1 && n < lim);
   endtask
   task automatic near(input int lo, input int hi);
      chk({7'h00, n >= lo && n <= hi}, 8'h01);
   endtask
   // The first period may lose up to one prescaler tick.
   task automatic first(input int k, input int q);
      wait_ev(k, q + 40);
      near(q - q / 128 - 4, q + 4);
   endtask
   task automatic do_reset();
      rst <= 1'b1;
      repeat (20) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // Clock, hang guard and main sequence
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   initial begin
      #(100 * 100000);
      failures++;
      summarize();
   end
   initial begin
      {rst, stop_mode, irq_mask_in, sw_wr, sw_val} = 5'b10000;
      wr_req = '0;
      seen = 3'b000;
      do_reset();
      chk(clksel_rd, 8'h00);
      chk(mode_rd, 8'h00);
      // Random period code. Odd codes are prohibited, so bit 0 is cleared;
      // bit 2 is cleared only to keep the run short.
      d = $random(seed);
      d[2] = 1'b0;
      d[0] = 1'b0;
      p = period(d);
      wr(WDT_CLKSEL_ADDR, d);
      chk(clksel_rd, d & 8'h07);
      wr(WDT_MODE_ADDR, 8'h88);
      chk(mode_rd, 8'h88);
      first(0, p);
      wait_ev(0, p + 40);
      near(p, p);
      repeat (2) @(posedge clk_sys);
      #1;
      chk(irq_req, 8'h01);
      chk(irq_top_prio, 8'h01);
      @(posedge clk_sys);
      irq_mask_in <= 1'b1;
      wr(WDT_MODE_ADDR, 8'h00);
      chk(irq_req, 8'h00);
      chk(irq_top_prio, 8'h00);
      chk(mode_rd, 8'h88);
      // Restart just before stop, then the frozen count must resume.
      wr(WDT_MODE_ADDR, 8'h80);
      @(posedge clk_sys);
      stop_mode <= 1'b1;
      wait_ev(0, 3 * p);
      near(3 * p, 3 * p);
      @(posedge clk_sys);
      stop_mode <= 1'b0;
      first(0, p);
      @(posedge clk_sys);
      do_reset();
      chk(clksel_rd, 8'h00);
      chk(mode_rd, 8'h00);
      // Running in mode zero must stay silent through two overflows.
      seen = 3'b000;
      wr(WDT_MODE_ADDR, 8'h80);
      repeat (2 * period(8'h00)) @(posedge clk_sys);
      #1;
      chk({5'h00, seen}, 8'h00);
      @(posedge clk_sys);
      {sw_wr, sw_val} <= 2'b11;
      wr(WDT_MODE_ADDR, 8'h90);
      chk({5'h00, seen}, 8'h02);
      @(posedge clk_sys);
      sw_val <= 1'b0;
      wr(WDT_MODE_ADDR, 8'h80);
      first(1, period(8'h00));
      wr(WDT_MODE_ADDR, 8'h88);
      chk(mode_rd, 8'h98);
      first(2, period(8'h00));
      summarize();
   end
endmodule
